// ### design/tlm_map.vh
`ifndef TLM_MAP_VH
`define TLM_MAP_VH
// register word offsets (byte addresses, one 32-bit word each)
`define TLM_OFS_CFG      8'h00
`define TLM_OFS_CTL      8'h04
`define TLM_OFS_LOAD_A   8'h08
`define TLM_OFS_LOAD_B   8'h0C
`define TLM_OFS_MATCH_A  8'h10
`define TLM_OFS_MATCH_B  8'h14
`define TLM_OFS_PRE_A    8'h18
`define TLM_OFS_PRE_B    8'h1C
`define TLM_OFS_PMT_A    8'h20
`define TLM_OFS_PMT_B    8'h24
`define TLM_OFS_CNT_A    8'h28
`define TLM_OFS_CNT_B    8'h2C
`define TLM_OFS_STAT     8'h30
`define TLM_OFS_IMASK    8'h34
// config register fields
`define TLM_CFG_WIDE     0
`define TLM_CFG_MODE_A   2
`define TLM_CFG_MODE_B   4
`define TLM_CFG_STALL_A  6
`define TLM_CFG_STALL_B  7
// half modes, two bits each
`define TLM_MODE_PERIOD  2'h0
`define TLM_MODE_CAPCNT  2'h1
`define TLM_MODE_PWM     2'h2
// control register fields
`define TLM_CTL_EN_A     0
`define TLM_CTL_EN_B     1
// status bits: match a, timeout a, match b, timeout b
`define TLM_ST_MATCH_A   0
`define TLM_ST_TOUT_A    1
`define TLM_ST_MATCH_B   2
`define TLM_ST_TOUT_B    3
`define TLM_ST_W         4
`endif

// ### design/tlm_sync2.v
`timescale 1ns/1ps
// two flip-flop synchroniser for one level from outside the clock domain
module tlm_sync2 (
  input  wire mclk_i,
  input  wire rst_i,
  input  wire d_i,
  output wire q_o
);
  reg meta_reg; // first stage, read only by the second
  reg sync_reg; // second stage, safe to use

  // plain shift of the level through two stages
  always @(posedge mclk_i) begin
    if (rst_i) begin
      meta_reg <= 1'b0;
      sync_reg <= 1'b0;
    end else begin
      meta_reg <= d_i;
      sync_reg <= meta_reg;
    end
  end

  assign q_o = sync_reg;
endmodule // tlm_sync2

// ### design/tlm_half.v
`timescale 1ns/1ps
`include "tlm_map.vh"
// one counter half: prescaler above a down counter, match compare, pwm output
module tlm_half #(
  parameter CW = 16, // counter width
  parameter PW = 8   // prescale width
) (
  input  wire          mclk_i,
  input  wire          rst_i,
  input  wire          run_i,      // enabled, not stalled and not joined
  input  wire          use_pre_i,  // half-width mode: prescaler active
  input  wire [1:0]    mode_i,
  input  wire          load_i,     // load strobe from a software write
  input  wire [CW-1:0] load_val_i,
  input  wire [PW-1:0] pre_val_i,
  input  wire [CW-1:0] match_i,
  input  wire [PW-1:0] pmatch_i,
  output wire [CW-1:0] cnt_o,
  output wire [PW-1:0] pre_o,
  output wire          match_o,    // one-cycle pulse on match
  output wire          tout_o,     // one-cycle pulse on wrap
  output wire          pwm_o
);
  reg  [CW-1:0] cnt_reg;
  reg  [PW-1:0] pre_reg;
  reg           pwm_reg;
  wire [PW-1:0] pre_eff = use_pre_i ? pre_reg : {PW{1'b0}}; // R8
  wire [PW-1:0] pmt_eff = use_pre_i ? pmatch_i : {PW{1'b0}}; // R8
  // prescaler sits above the counter, so the pair is one extended count
  wire [PW+CW-1:0] ext_cnt = {pre_eff, cnt_reg}; // R15
  wire [PW+CW-1:0] ext_mt  = {pmt_eff, match_i}; // R10
  wire          at_zero = (ext_cnt == {(PW+CW){1'b0}});
  wire          hit     = run_i && (ext_cnt == ext_mt);

  // down count of the extended value; a load write takes effect at once
  always @(posedge mclk_i) begin
    if (rst_i) begin
      cnt_reg <= {CW{1'b1}};
      pre_reg <= {PW{1'b0}};
    end else if (load_i) begin
      cnt_reg <= load_val_i; // R1
      pre_reg <= pre_val_i;
    end else if (run_i) begin
      if (at_zero) begin
        cnt_reg <= load_val_i;
        pre_reg <= pre_val_i;
      end else if (cnt_reg == {CW{1'b0}}) begin
        cnt_reg <= {CW{1'b1}};
        pre_reg <= use_pre_i ? pre_reg - 1'b1 : {PW{1'b0}}; // R15
      end else begin
        cnt_reg <= cnt_reg - 1'b1;
      end
    end
  end

  // pwm high from reload until the count falls to the match value
  always @(posedge mclk_i) begin
    if (rst_i) begin
      pwm_reg <= 1'b0;
    end else if (mode_i != `TLM_MODE_PWM) begin
      pwm_reg <= 1'b0;
    end else if (run_i && at_zero) begin
      pwm_reg <= 1'b1;
    end else if (hit) begin
      pwm_reg <= 1'b0; // R6
    end
  end

  assign cnt_o   = cnt_reg;
  assign pre_o   = pre_reg;
  assign match_o = hit && (mode_i == `TLM_MODE_CAPCNT); // R5
  assign tout_o  = run_i && at_zero && (mode_i == `TLM_MODE_PERIOD);
  assign pwm_o   = pwm_reg;
endmodule // tlm_half

// ### design/tlm_top.v
// Summary of operation
// R1: load write reloads running counter immediately
// R2: load value reads back per half
// R3: full-width accesses use half A only
// R4: wide variant full-width gives 64-bit values
// R5: capture count match raises interrupt event
// R6: match value sets pwm duty cycle
// R7: match value reads back, 64-bit when wide
// R8: prescaler acts only in half-width mode
// R9: prescale fields 8 or 16 bits wide
// R10: prescale match extends match range
// R11: prescaler and prescale match readable
// R12: writes hit A, B or both; reads one
// R13: stall enable stops counting in debug
// R14: only enabled sources reach interrupt output
// R15: prescaler forms top bits of count
//
// The address map and the address-and-strobe port were chosen for this implementation.
`timescale 1ns/1ps
`include "tlm_map.vh"
module tlm_top #(
  parameter HW = 16, // half width: 16 narrow, 32 wide variant
  parameter PW = 8   // prescale width: 8 narrow, 16 wide variant
) (
  input  wire        mclk_i,
  input  wire        rst_i,
  input  wire [7:0]  addr_i,
  input  wire [31:0] wdata_i,
  input  wire        wr_i,
  input  wire        rd_i,
  input  wire        both_i,   // write also targets half B
  input  wire        debug_i,  // processor halted, from another domain
  output reg  [31:0] rdata_o,
  output wire        pwm_a_o,
  output wire        pwm_b_o,
  output wire        irq_o
);
  localparam FW = 2 * HW; // joined full width
  localparam ONE_WORD = (FW <= 32); // joined value fits one bus word, reached via half a

  reg  [7:0]    cfg_reg;   // wide, modes, stall enables
  reg  [1:0]    ctl_reg;   // enables a and b
  reg  [HW-1:0] load_a_reg;
  reg  [HW-1:0] load_b_reg;
  reg  [HW-1:0] match_a_reg;
  reg  [HW-1:0] match_b_reg;
  reg  [PW-1:0] pre_a_reg;
  reg  [PW-1:0] pre_b_reg;
  reg  [PW-1:0] pmt_a_reg;
  reg  [PW-1:0] pmt_b_reg;
  reg  [`TLM_ST_W-1:0] stat_reg;
  reg  [`TLM_ST_W-1:0] imask_reg;
  reg  [FW-1:0] wcnt_reg;  // joined counter for full-width mode
  reg           ld_a_reg;
  reg           ld_b_reg;
  wire          dbg_s;
  wire [HW-1:0] cnt_a;
  wire [HW-1:0] cnt_b;
  wire [PW-1:0] pv_a;
  wire [PW-1:0] pv_b;
  wire          m_a;
  wire          m_b;
  wire          t_a;
  wire          t_b;

  // register decode shared by write and read paths
  function is_addr;
    input [7:0] a;
    input [7:0] ofs;
    begin
      is_addr = (a == ofs);
    end
  endfunction

  wire wide    = cfg_reg[`TLM_CFG_WIDE];
  wire [1:0] mode_a = cfg_reg[`TLM_CFG_MODE_A+1:`TLM_CFG_MODE_A];
  wire [1:0] mode_b = cfg_reg[`TLM_CFG_MODE_B+1:`TLM_CFG_MODE_B];
  wire stall_a = cfg_reg[`TLM_CFG_STALL_A] && dbg_s; // R13
  wire stall_b = cfg_reg[`TLM_CFG_STALL_B] && dbg_s; // R13
  wire run_a   = ctl_reg[`TLM_CTL_EN_A] && !stall_a && !wide;
  wire run_b   = ctl_reg[`TLM_CTL_EN_B] && !stall_b && !wide;
  wire run_w   = ctl_reg[`TLM_CTL_EN_A] && !stall_a && wide;
  wire wr_b    = wr_i && both_i; // R12
  // upper half of a one-word joined value; zero on the wide variant
  wire [31:0] wd_hi = wdata_i >> HW;

  // debug level crosses in from the processor's domain
  tlm_sync2 u_dbg (
    .mclk_i (mclk_i),
    .rst_i  (rst_i),
    .d_i    (debug_i),
    .q_o    (dbg_s)
  );

  // half A, prescaler active only when not joined
  tlm_half #(.CW(HW), .PW(PW)) u_half_a (
    .mclk_i     (mclk_i),
    .rst_i      (rst_i),
    .run_i      (run_a),
    .use_pre_i  (!wide), // R8
    .mode_i     (mode_a),
    .load_i     (ld_a_reg),
    .load_val_i (load_a_reg),
    .pre_val_i  (pre_a_reg),
    .match_i    (match_a_reg),
    .pmatch_i   (pmt_a_reg),
    .cnt_o      (cnt_a),
    .pre_o      (pv_a),
    .match_o    (m_a),
    .tout_o     (t_a),
    .pwm_o      (pwm_a_o)
  );

  // half B, independent in half-width mode
  tlm_half #(.CW(HW), .PW(PW)) u_half_b (
    .mclk_i     (mclk_i),
    .rst_i      (rst_i),
    .run_i      (run_b),
    .use_pre_i  (!wide), // R8
    .mode_i     (mode_b),
    .load_i     (ld_b_reg),
    .load_val_i (load_b_reg),
    .pre_val_i  (pre_b_reg),
    .match_i    (match_b_reg),
    .pmatch_i   (pmt_b_reg),
    .cnt_o      (cnt_b),
    .pre_o      (pv_b),
    .match_o    (m_b),
    .tout_o     (t_b),
    .pwm_o      (pwm_b_o)
  );

  // joined value views: B holds the upper word in full-width mode
  wire [FW-1:0] wload  = {load_b_reg, load_a_reg};  // R4
  wire [FW-1:0] wmatch = {match_b_reg, match_a_reg}; // R4
  wire          w_zero = (wcnt_reg == {FW{1'b0}});
  wire          w_hit  = run_w && (wcnt_reg == wmatch) && (mode_a == `TLM_MODE_CAPCNT);
  wire          w_tout = run_w && w_zero && (mode_a == `TLM_MODE_PERIOD);

  // full-width counter, no prescaler in this mode
  always @(posedge mclk_i) begin
    if (rst_i) begin
      wcnt_reg <= {FW{1'b1}};
    end else if (ld_a_reg || ld_b_reg) begin
      wcnt_reg <= wload; // R1
    end else if (run_w) begin
      wcnt_reg <= w_zero ? wload : wcnt_reg - 1'b1;
    end
  end

  // register writes; load writes also raise a reload strobe next cycle
  always @(posedge mclk_i) begin
    if (rst_i) begin
      cfg_reg     <= 8'h00;
      ctl_reg     <= 2'h0;
      load_a_reg  <= {HW{1'b1}};
      load_b_reg  <= {HW{1'b1}};
      match_a_reg <= {HW{1'b0}};
      match_b_reg <= {HW{1'b0}};
      pre_a_reg   <= {PW{1'b0}};
      pre_b_reg   <= {PW{1'b0}};
      pmt_a_reg   <= {PW{1'b0}};
      pmt_b_reg   <= {PW{1'b0}};
      imask_reg   <= {`TLM_ST_W{1'b0}};
      ld_a_reg    <= 1'b0;
      ld_b_reg    <= 1'b0;
    end else begin
      ld_a_reg <= 1'b0;
      ld_b_reg <= 1'b0;
      if (wr_i) begin
        if (is_addr(addr_i, `TLM_OFS_CFG)) begin
          cfg_reg <= wdata_i[7:0];
        end else if (is_addr(addr_i, `TLM_OFS_CTL)) begin
          ctl_reg <= wdata_i[1:0];
        end else if (is_addr(addr_i, `TLM_OFS_LOAD_A)) begin
          load_a_reg <= wdata_i[HW-1:0];
          ld_a_reg   <= 1'b1; // R1
          if (wide && ONE_WORD) begin
            // narrow variant joined: the single word through half a fills both halves
            load_b_reg <= wd_hi[HW-1:0]; // R4
            ld_b_reg   <= 1'b1;
          end else if (wr_b) begin
            load_b_reg <= wdata_i[HW-1:0]; // R12
            ld_b_reg   <= 1'b1;
          end
        end else if (is_addr(addr_i, `TLM_OFS_LOAD_B)) begin
          load_b_reg <= wdata_i[HW-1:0];
          ld_b_reg   <= 1'b1; // R1
        end else if (is_addr(addr_i, `TLM_OFS_MATCH_A)) begin
          match_a_reg <= wdata_i[HW-1:0];
          if (wide && ONE_WORD) begin
            match_b_reg <= wd_hi[HW-1:0]; // R4
          end else if (wr_b) begin
            match_b_reg <= wdata_i[HW-1:0]; // R12
          end
        end else if (is_addr(addr_i, `TLM_OFS_MATCH_B)) begin
          match_b_reg <= wdata_i[HW-1:0];
        end else if (is_addr(addr_i, `TLM_OFS_PRE_A)) begin
          pre_a_reg <= wdata_i[PW-1:0]; // R9
          if (wr_b) begin
            pre_b_reg <= wdata_i[PW-1:0];
          end
        end else if (is_addr(addr_i, `TLM_OFS_PRE_B)) begin
          pre_b_reg <= wdata_i[PW-1:0]; // R9
        end else if (is_addr(addr_i, `TLM_OFS_PMT_A)) begin
          pmt_a_reg <= wdata_i[PW-1:0]; // R9
          if (wr_b) begin
            pmt_b_reg <= wdata_i[PW-1:0];
          end
        end else if (is_addr(addr_i, `TLM_OFS_PMT_B)) begin
          pmt_b_reg <= wdata_i[PW-1:0]; // R9
        end else if (is_addr(addr_i, `TLM_OFS_IMASK)) begin
          imask_reg <= wdata_i[`TLM_ST_W-1:0];
        end
      end
    end
  end

  // event collection: each bit sticks; write one clears, a new event wins
  wire [`TLM_ST_W-1:0] evt = {t_b, m_b, (t_a | w_tout), (m_a | w_hit)}; // R5
  wire stat_clr = wr_i && is_addr(addr_i, `TLM_OFS_STAT);
  always @(posedge mclk_i) begin
    if (rst_i) begin
      stat_reg <= {`TLM_ST_W{1'b0}};
    end else begin
      stat_reg <= (stat_reg & ~(stat_clr ? wdata_i[`TLM_ST_W-1:0] : {`TLM_ST_W{1'b0}})) | evt;
    end
  end

  // only enabled sources reach the processor
  assign irq_o = |(stat_reg & imask_reg); // R14

  // read mux; unmapped addresses read zero
  // in full-width mode the load, match and count B offsets return the upper half of the joined value
  always @(posedge mclk_i) begin
    if (rst_i) begin
      rdata_o <= 32'h00000000;
    end else if (rd_i) begin
      rdata_o <= 32'h00000000;
      if (is_addr(addr_i, `TLM_OFS_CFG)) begin
        rdata_o[7:0] <= cfg_reg;
      end else if (is_addr(addr_i, `TLM_OFS_CTL)) begin
        rdata_o[1:0] <= ctl_reg;
      end else if (is_addr(addr_i, `TLM_OFS_LOAD_A)) begin
        if (wide) begin
          rdata_o <= wload[31:0]; // R4
        end else begin
          rdata_o[HW-1:0] <= load_a_reg; // R2
        end
      end else if (is_addr(addr_i, `TLM_OFS_LOAD_B)) begin
        rdata_o[HW-1:0] <= load_b_reg; // R2
      end else if (is_addr(addr_i, `TLM_OFS_MATCH_A)) begin
        if (wide) begin
          rdata_o <= wmatch[31:0]; // R7
        end else begin
          rdata_o[HW-1:0] <= match_a_reg; // R7
        end
      end else if (is_addr(addr_i, `TLM_OFS_MATCH_B)) begin
        rdata_o[HW-1:0] <= match_b_reg; // R7
      end else if (is_addr(addr_i, `TLM_OFS_PRE_A)) begin
        rdata_o[PW-1:0] <= pv_a; // R11
      end else if (is_addr(addr_i, `TLM_OFS_PRE_B)) begin
        rdata_o[PW-1:0] <= pv_b; // R11
      end else if (is_addr(addr_i, `TLM_OFS_PMT_A)) begin
        rdata_o[PW-1:0] <= pmt_a_reg; // R11
      end else if (is_addr(addr_i, `TLM_OFS_PMT_B)) begin
        rdata_o[PW-1:0] <= pmt_b_reg; // R11
      end else if (is_addr(addr_i, `TLM_OFS_CNT_A)) begin
        if (wide) begin
          rdata_o <= wcnt_reg[31:0]; // R3
        end else begin
          rdata_o[HW-1:0] <= cnt_a;
        end
      end else if (is_addr(addr_i, `TLM_OFS_CNT_B)) begin
        rdata_o[HW-1:0] <= wide ? wcnt_reg[FW-1:HW] : cnt_b;
      end else if (is_addr(addr_i, `TLM_OFS_STAT)) begin
        rdata_o[`TLM_ST_W-1:0] <= stat_reg;
      end else if (is_addr(addr_i, `TLM_OFS_IMASK)) begin
        rdata_o[`TLM_ST_W-1:0] <= imask_reg;
      end
    end
  end
endmodule // tlm_top

// ### testbench/tlm_top_properties.sv
`timescale 1ns/1ps
`include "tlm_map.vh"
// watches the register port of the timer top from outside, with shadows of what was written
module tlm_top_properties #(
  parameter HW = 16,
  parameter PW = 8
) (
  input wire        mclk_i,
  input wire        rst_i,
  input wire [7:0]  addr_i,
  input wire [31:0] wdata_i,
  input wire        wr_i,
  input wire        rd_i,
  input wire        both_i,
  input wire        debug_i,
  input wire [31:0] rdata_o,
  input wire        pwm_a_o,
  input wire        pwm_b_o,
  input wire        irq_o
);
  localparam [63:0] HM = (64'h1 << HW) - 64'h1; // counter field mask
  localparam [63:0] PM = (64'h1 << PW) - 64'h1; // prescale field mask
  reg [31:0] ld_a_reg;                          // programmed load, half a
  reg [31:0] ld_b_reg;                          // programmed load, half b
  reg [31:0] mt_a_reg;                          // programmed match, half a
  reg [31:0] mt_b_reg;                          // programmed match, half b
  reg        wd_reg;                            // full-width mode selected
  reg [31:0] pm_a_reg;                          // programmed prescale match, half a
  reg [3:0]  im_reg;                            // interrupt mask
  reg [1:0]  en_reg;                            // half enables
  wire       wa = wr_i && addr_i == `TLM_OFS_LOAD_A;
  wire       wm = wr_i && addr_i == `TLM_OFS_MATCH_A;
  localparam JN = (2 * HW <= 32);               // joined value fits one bus word
  // what a half a read returns: in full width the low word of the joined value
  wire [63:0] ja = wd_reg ? (({32'h0, ld_b_reg} << HW) | {32'h0, ld_a_reg})
                          : {32'h0, ld_a_reg};
  wire [63:0] jm = wd_reg ? (({32'h0, mt_b_reg} << HW) | {32'h0, mt_a_reg})
                          : {32'h0, mt_a_reg};
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (rst_i);
  // shadows; a both-halves write lands in b too, so b is checked as well
  always @(posedge mclk_i) begin
    if (rst_i) begin
      ld_a_reg <= HM[31:0];
      ld_b_reg <= HM[31:0];
      mt_a_reg <= 32'h0;
      mt_b_reg <= 32'h0;
      wd_reg   <= 1'b0;
      pm_a_reg <= 32'h0;
      im_reg   <= 4'h0;
      en_reg   <= 2'h0;
    end else begin
      if (wa) ld_a_reg <= wdata_i & HM[31:0];
      if (wa && wd_reg && JN) ld_b_reg <= (wdata_i >> HW) & HM[31:0];
      else if ((wa && both_i) || (wr_i && addr_i == `TLM_OFS_LOAD_B))
        ld_b_reg <= wdata_i & HM[31:0];
      if (wm) mt_a_reg <= wdata_i & HM[31:0];
      if (wm && wd_reg && JN) mt_b_reg <= (wdata_i >> HW) & HM[31:0];
      else if ((wm && both_i) || (wr_i && addr_i == `TLM_OFS_MATCH_B))
        mt_b_reg <= wdata_i & HM[31:0];
      if (wr_i && addr_i == `TLM_OFS_CFG) wd_reg <= wdata_i[`TLM_CFG_WIDE];
      if (wr_i && addr_i == `TLM_OFS_PMT_A) pm_a_reg <= wdata_i & PM[31:0];
      if (wr_i && addr_i == `TLM_OFS_IMASK) im_reg <= wdata_i[3:0];
      if (wr_i && addr_i == `TLM_OFS_CTL) en_reg <= wdata_i[1:0];
    end
  end
  a_rdata_holds: assert property (!rd_i |=> $stable(rdata_o))
    else $error("read data moved without a read");
  a_load_a_read: assert property (rd_i && addr_i == `TLM_OFS_LOAD_A |=> rdata_o == ja[31:0])
    else $error("load a read back wrong");
  a_load_b_read: assert property (rd_i && addr_i == `TLM_OFS_LOAD_B |=> rdata_o == ld_b_reg)
    else $error("load b read back wrong");
  a_match_a_read: assert property (rd_i && addr_i == `TLM_OFS_MATCH_A |=> rdata_o == jm[31:0])
    else $error("match a read back wrong");
  a_pmatch_read: assert property (rd_i && addr_i == `TLM_OFS_PMT_A |=> rdata_o == pm_a_reg)
    else $error("prescale match read back wrong");
  a_irq_masked: assert property (im_reg == 4'h0 |-> !irq_o)
    else $error("interrupt with all sources masked");
  a_irq_cleared: assert property (en_reg == 2'h0 && wr_i && addr_i == `TLM_OFS_STAT
    && wdata_i[3:0] == 4'hF |=> !irq_o[*2]) else $error("interrupt survived clear");
  a_unmapped_zero: assert property (rd_i && addr_i >= 8'h38 |=> rdata_o == 32'h0)
    else $error("unmapped read not zero");
  c_read: cover property (rd_i && addr_i == `TLM_OFS_LOAD_A);
  c_irq: cover property ($rose(irq_o));
  c_pwm: cover property ($rose(pwm_a_o));
endmodule // tlm_top_properties

// ### testbench/tlm_top_tb_top.sv
`timescale 1ns/1ps
// register-port bench: random programming, reload, prescale, match, pwm
module tlm_top_tb_top;
  reg         mclk_i = 0;  // 50 MHz
  reg         rst_i = 1;
  reg  [7:0]  addr_i = 0;
  reg  [31:0] wdata_i = 0;
  reg         wr_i = 0;
  reg         rd_i = 0;
  reg         both_i = 0;
  reg         debug_i = 0; // processor debug level, drives the stall path
  wire [31:0] rdata_o;
  wire        pwm_a_o;
  wire        pwm_b_o;
  wire        irq_o;
  integer     n_fail = 0;
  integer     check_count = 0;
  integer     seed = 8831;
  integer     i;
  integer     hi;
  integer     hb;
  reg  [31:0] got;
  reg  [31:0] v;
  reg  [31:0] e [0:5];     // expected values per readback offset
  always #10 mclk_i = ~mclk_i;
  tlm_top #(.HW(16), .PW(8)) i_dut (.mclk_i(mclk_i), .rst_i(rst_i), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .both_i(both_i), .debug_i(debug_i),
    .rdata_o(rdata_o), .pwm_a_o(pwm_a_o), .pwm_b_o(pwm_b_o), .irq_o(irq_o));
  task end_of_test;
    $display("checks %0d errors %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task check(input [31:0] g, input [31:0] x);
    check_count = check_count + 1;
    if (g !== x) begin
      n_fail = n_fail + 1;
      $display("Error at %0t: got %h want %h", $time, g, x);
    end
  endtask
  // range compare where a running counter makes the exact cycle loose
  task check_rng(input [31:0] g, input [31:0] lo, input [31:0] up);
    check_count = check_count + 1;
    if (!(g >= lo && g <= up)) begin
      n_fail = n_fail + 1;
      $display("Error at %0t: got %h outside %h..%h", $time, g, lo, up);
    end
  endtask
  // pwm high phase in cycles: every count from the reload value down to the match value
  function integer duty_len(input integer ld, input integer mt);
    duty_len = ld - mt + 1;
  endfunction
  // one-cycle write; a following rd or idle lowers the strobe at the next edge, a following wr keeps it for its own write
  task wr(input [7:0] a, input [31:0] d, input b);
    @(posedge mclk_i);
    addr_i <= a; wdata_i <= d; both_i <= b; wr_i <= 1'b1; rd_i <= 1'b0;
  endtask
  // read data stand from the cycle after the strobe until the next read
  task rd(input [7:0] a);
    @(posedge mclk_i);
    addr_i <= a; rd_i <= 1'b1; wr_i <= 1'b0;
    @(posedge mclk_i);
    rd_i <= 1'b0; wr_i <= 1'b0;
    #1 got = rdata_o;
  endtask
  task idle(input integer n);
    repeat (n) begin
      @(posedge mclk_i);
      wr_i <= 1'b0; rd_i <= 1'b0;
    end
  endtask
  // hang guard: the whole sequence needs about 530 cycles, the guard allows 20000
  initial begin
    #400000;
    n_fail = n_fail + 1;
    end_of_test;
  end
  initial begin
    repeat (3) @(posedge mclk_i);
    rst_i <= 1'b0;
    rd(8'h08); check(got, 32'h0000FFFF);
    rd(8'h20); check(got, 32'h0);
    rd(8'h3C); check(got, 32'h0);
    e[0] = 32'hFFFF; e[1] = 32'hFFFF; e[2] = 0; e[3] = 0; e[4] = 0; e[5] = 0;
    // random values written back to back, a and b separately or both at once
    for (i = 0; i < 16; i = i + 1) begin
      v = $random(seed);
      hi = $random(seed) & 1;
      wr(8'h08, v[15:0], hi[0]); e[0] = v[15:0]; if (hi[0]) e[1] = e[0];
      wr(8'h14, v[31:16], 1'b0); e[3] = v[31:16];
      wr(8'h10, v[23:8], ~hi[0]); e[2] = v[23:8]; if (!hi[0]) e[3] = e[2];
      wr(8'h20, v[7:0], hi[0]); e[4] = v[7:0]; if (hi[0]) e[5] = e[4];
      rd(8'h08); check(got, e[0]);
      rd(8'h0C); check(got, e[1]);
      rd(8'h10); check(got, e[2]);
      rd(8'h14); check(got, e[3]);
      rd(8'h20); check(got, e[4]);
      rd(8'h24); check(got, e[5]);
    end
    // reload while running takes effect at once
    wr(8'h00, 32'h0, 1'b0); wr(8'h04, 32'h1, 1'b0); idle(5);
    wr(8'h08, 32'h1000, 1'b0); idle(3);
    rd(8'h28); check_rng(got, 32'h0FF0, 32'h1000);
    // prescaler sits above the counter in half width
    wr(8'h18, 32'h5, 1'b0); wr(8'h08, 32'h2, 1'b0); idle(10);
    rd(8'h18); check(got, 32'h4);
    rd(8'h28); check_rng(got, 32'hFFE0, 32'hFFFF);
    // full width joins the halves through half a alone, the prescaler stays out of it
    wr(8'h00, 32'h1, 1'b0); wr(8'h08, 32'h100, 1'b0); idle(8);
    rd(8'h28); check_rng(got, 32'hE0, 32'h100);
    rd(8'h08); check(got, 32'h100);
    // capture count: match event, masking and clearing
    wr(8'h04, 32'h0, 1'b0); wr(8'h00, 32'h4, 1'b0); wr(8'h18, 32'h0, 1'b0);
    wr(8'h20, 32'h0, 1'b1); wr(8'h10, 32'h10, 1'b1); wr(8'h34, 32'h0, 1'b0);
    wr(8'h04, 32'h1, 1'b0); wr(8'h08, 32'h20, 1'b0); idle(40);
    #1 check({31'h0, irq_o}, 32'h0);
    rd(8'h30); check(got & 32'h1, 32'h1);
    wr(8'h34, 32'h1, 1'b0); idle(1);
    #1 check({31'h0, irq_o}, 32'h1);
    wr(8'h04, 32'h0, 1'b0); idle(2); wr(8'h30, 32'hF, 1'b0); idle(1);
    #1 check({31'h0, irq_o}, 32'h0);
    // pwm on both halves: high from reload 0x40 down to match 0x10, period 0x41;
    // loaded before enabling, so the window holds exactly one whole high phase
    wr(8'h00, 32'h28, 1'b0); wr(8'h08, 32'h40, 1'b1); wr(8'h04, 32'h3, 1'b0);
    hi = 0;
    hb = 0;
    repeat (130) begin
      idle(1);
      #1 hi = hi + pwm_a_o;
      hb = hb + pwm_b_o;
    end
    check(hi, duty_len(32'h40, 32'h10));
    check(hb, duty_len(32'h40, 32'h10));
    // stall in debug: the count freezes while the level is high, then runs on
    wr(8'h00, 32'h40, 1'b0); wr(8'h08, 32'h8000, 1'b0);
    debug_i <= 1'b1;
    idle(4);
    rd(8'h28); check(got, 32'h8000);
    idle(10);
    rd(8'h28); check(got, 32'h8000);
    debug_i <= 1'b0;
    idle(6);
    rd(8'h28); check_rng(got, 32'h7FE0, 32'h7FFF);
    idle(1);
    end_of_test;
  end
endmodule // tlm_top_tb_top
bind tlm_top tlm_top_properties #(.HW(HW), .PW(PW)) i_props (.mclk_i(mclk_i), .rst_i(rst_i),
  .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .both_i(both_i),
  .debug_i(debug_i), .rdata_o(rdata_o), .pwm_a_o(pwm_a_o), .pwm_b_o(pwm_b_o), .irq_o(irq_o));
